// File: scd_consts.svh
// Purpose: constants of the strap clock configuration decoder
// Assumes: 25 MHz core clock; i/o ports are byte wide
// Notes:   included by the package, the decoder module and the bench
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// ----------------------------------------------------------------
// i/o port pair and register index
// ----------------------------------------------------------------
`define SCD_INDEX_PORT      16'h0022
`define SCD_DATA_PORT       16'h0023
`define SCD_MIRROR_INDEX    8'h5f
`define SCD_INDEX_RESET     8'h00
`define SCD_RDATA_RESET     8'h00
`define SCD_RSV_BITS        3'h0

// ----------------------------------------------------------------
// strap line positions
// ----------------------------------------------------------------
`define SCD_STRAP_WIDTH     47
`define SCD_LN_HF4          3
`define SCD_LN_HF3          2
`define SCD_LN_HF2          26
`define SCD_LN_HF1          25
`define SCD_LN_HF0          24
`define SCD_LN_MUL_HI       40
`define SCD_LN_MUL_LO       14
`define SCD_LN_TIC_HI       43
`define SCD_LN_TIC_LO       41
`define SCD_LN_BUS_SEL      44
`define SCD_LN_RANGE_HI     46
`define SCD_LN_RANGE_LO     45

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCD_CLK_PERIOD_NS   40
`define SCD_RSTO_DELAY_NS   1000
`define SCD_RSTO_DELAY_CYC  ((`SCD_RSTO_DELAY_NS + `SCD_CLK_PERIOD_NS - 1) / `SCD_CLK_PERIOD_NS)
`define SCD_CNT_WIDTH       5

`endif

// File: scd_pkg.sv
// Purpose: types of the strap clock configuration decoder
// Assumes: scd_consts.svh holds the numbers
// Notes:   none
`include "scd_consts.svh"

package scd_pkg;
    typedef logic [`SCD_STRAP_WIDTH-1:0] scd_strap_t;
    typedef enum logic [1:0] {
        SCD_RANGE_16_32,
        SCD_RANGE_32_64,
        SCD_RANGE_ABOVE_64,
        SCD_RANGE_RESERVED
    } scd_range_t;
    typedef enum logic {
        SCD_BUS_ISA,
        SCD_BUS_LOCAL
    } scd_bus_t;
    typedef enum logic [1:0] {
        SCD_ST_HOLD,
        SCD_ST_COUNT,
        SCD_ST_RUN
    } scd_state_t;
endpackage

// File: scd_cfg_if.sv
// Purpose: carries sampled straps from the sampler to the decoder
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/100ps
`default_nettype none

interface scd_cfg_if;
    import scd_pkg::*;
    scd_strap_t straps;
    logic       pin_high;
    modport src (output straps, output pin_high);
    modport dst (input straps, input pin_high);
endinterface

`default_nettype wire

// File: scd_strap_sampler.sv
// Purpose: synchronises reset pin and strap lines, samples straps during reset
// Assumes: strap lines and reset pin are asynchronous board levels
// Notes:   first synchroniser stage is read only by the second
`timescale 1ns/100ps
`default_nettype none

module scd_strap_sampler
    import scd_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        system_reset_input_n_in,
    input  wire scd_strap_t  strap_memory_data_line_in,
    scd_cfg_if.src           cfg
);
    scd_strap_t strap_meta_ff;
    scd_strap_t strap_sync_ff;
    scd_strap_t strap_hold_ff;
    logic       rst_meta_ff;
    logic       rst_sync_ff;
    scd_strap_t nxt_strap_hold;

    // ----------------------------------------------------------------
    // sampling: track while reset pin low, freeze on release
    // ----------------------------------------------------------------
    always_comb begin
        nxt_strap_hold = strap_hold_ff;
        if (!rst_sync_ff) begin
            nxt_strap_hold = strap_sync_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            strap_meta_ff <= '0;
            strap_sync_ff <= '0;
            strap_hold_ff <= '0;
            rst_meta_ff   <= 1'b0;
            rst_sync_ff   <= 1'b0;
        end else begin
            strap_meta_ff <= strap_memory_data_line_in;
            strap_sync_ff <= strap_meta_ff;
            strap_hold_ff <= nxt_strap_hold;
            rst_meta_ff   <= system_reset_input_n_in;
            rst_sync_ff   <= rst_meta_ff;
        end
    end

    assign cfg.straps   = strap_hold_ff;
    assign cfg.pin_high = rst_sync_ff;

    a_hold_frozen: assert property (@(posedge clock_in) disable iff (reset_in)
        $past(rst_sync_ff) && rst_sync_ff |-> $stable(strap_hold_ff))
        else $error("straps changed after reset release");
endmodule

`default_nettype wire

// File: strap_clock_config_decoder.sv
// Purpose: decodes reset-time straps into clock and bus configuration
// Assumes: i/o strobes are one-cycle pulses on clock_in
// Notes:   straps are sampled by scd_strap_sampler
`timescale 1ns/100ps
`default_nettype none
`include "scd_consts.svh"

module strap_clock_config_decoder
    import scd_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        system_reset_input_n_in,
    input  wire scd_strap_t  strap_memory_data_line_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_wr_in,
    input  wire logic        io_rd_in,
    input  wire logic [7:0]  io_wdata_in,
    output logic      [7:0]  io_rdata_out,
    output logic      [7:0]  host_clock_freq_mhz_out,
    output logic             host_clock_code_valid_out,
    output logic      [1:0]  host_clock_input_range_select_out,
    output logic             host_clock_pll_enable_out,
    output logic      [2:0]  core_multiplier_select_out,
    output logic      [2:0]  core_dll_tic_out,
    output logic             isa_bus_enable_out,
    output logic             local_bus_enable_out,
    output logic             system_reset_output_n_out
);
    scd_cfg_if cfg ();

    scd_strap_sampler u_sampler (
        .clock_in                  (clock_in),
        .reset_in                  (reset_in),
        .system_reset_input_n_in   (system_reset_input_n_in),
        .strap_memory_data_line_in (strap_memory_data_line_in),
        .cfg                       (cfg.src)
    );

    localparam logic [`SCD_CNT_WIDTH-1:0] RSTO_LAST = `SCD_CNT_WIDTH'(`SCD_RSTO_DELAY_CYC - 1);

    logic [4:0]  hclk_code;
    logic [7:0]  mirror;
    logic [7:0]  index_ff;
    logic [7:0]  nxt_index;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  freq_ff;
    logic [7:0]  nxt_freq;
    logic        freq_ok_ff;
    logic        nxt_freq_ok;
    scd_range_t  range_ff;
    scd_range_t  nxt_range;
    logic        pll_en_ff;
    logic        nxt_pll_en;
    logic [2:0]  mult_ff;
    logic [2:0]  nxt_mult;
    logic [2:0]  tic_ff;
    logic [2:0]  nxt_tic;
    scd_bus_t    nxt_bus;
    logic        isa_en_ff;
    logic        nxt_isa_en;
    logic        loc_en_ff;
    logic        nxt_loc_en;
    scd_state_t  state_ff;
    scd_state_t  nxt_state;
    logic [`SCD_CNT_WIDTH-1:0] cnt_ff;
    logic [`SCD_CNT_WIDTH-1:0] nxt_cnt;
    logic        rsto_ff;
    logic        nxt_rsto;

    // ----------------------------------------------------------------
    // strap decode
    // ----------------------------------------------------------------
    assign hclk_code = {cfg.straps[`SCD_LN_HF4], cfg.straps[`SCD_LN_HF3], cfg.straps[`SCD_LN_HF2],
                        cfg.straps[`SCD_LN_HF1], cfg.straps[`SCD_LN_HF0]};
    assign mirror    = {hclk_code, `SCD_RSV_BITS};

    always_comb begin
        nxt_freq_ok = 1'b1;
        case (hclk_code)
            5'h00:   nxt_freq = 8'h19;
            5'h01:   nxt_freq = 8'h32;
            5'h02:   nxt_freq = 8'h3c;
            5'h03:   nxt_freq = 8'h42;
            5'h09:   nxt_freq = 8'h4b;
            5'h13:   nxt_freq = 8'h5a;
            5'h19:   nxt_freq = 8'h64;
            5'h1f:   nxt_freq = 8'h85;
            default: begin
                nxt_freq    = 8'h00;
                nxt_freq_ok = 1'b0;
            end
        endcase
        nxt_range  = scd_range_t'(cfg.straps[`SCD_LN_RANGE_HI:`SCD_LN_RANGE_LO]);
        nxt_pll_en = (nxt_range != SCD_RANGE_RESERVED);
        unique case ({cfg.straps[`SCD_LN_MUL_HI], cfg.straps[`SCD_LN_MUL_LO]})
            2'b00: nxt_mult = 3'h4;
            2'b01: nxt_mult = 3'h1;
            2'b10: nxt_mult = 3'h3;
            2'b11: nxt_mult = 3'h2;
        endcase
        nxt_tic    = cfg.straps[`SCD_LN_TIC_HI:`SCD_LN_TIC_LO];
        nxt_bus    = scd_bus_t'(cfg.straps[`SCD_LN_BUS_SEL]);
        nxt_isa_en = (nxt_bus == SCD_BUS_ISA);
        nxt_loc_en = (nxt_bus == SCD_BUS_LOCAL);
    end

    // ----------------------------------------------------------------
    // index/data port pair
    // ----------------------------------------------------------------
    always_comb begin
        nxt_index = index_ff;
        nxt_rdata = rdata_ff;
        if (io_wr_in && io_addr_in == `SCD_INDEX_PORT) begin
            nxt_index = io_wdata_in;
        end
        if (io_rd_in) begin
            if (io_addr_in == `SCD_INDEX_PORT) begin
                nxt_rdata = index_ff;
            end else if (io_addr_in == `SCD_DATA_PORT && index_ff == `SCD_MIRROR_INDEX) begin
                nxt_rdata = mirror;
            end else begin
                nxt_rdata = `SCD_RDATA_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset output sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_rsto  = rsto_ff;
        if (!cfg.pin_high) begin
            nxt_state = SCD_ST_HOLD;
            nxt_cnt   = '0;
            nxt_rsto  = 1'b0;
        end else begin
            unique case (state_ff)
                SCD_ST_HOLD: begin
                    nxt_state = SCD_ST_COUNT;
                    nxt_cnt   = '0;
                end
                SCD_ST_COUNT: begin
                    if (cnt_ff == RSTO_LAST) begin
                        nxt_state = SCD_ST_RUN;
                        nxt_rsto  = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                SCD_ST_RUN: begin
                    nxt_rsto = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            index_ff   <= `SCD_INDEX_RESET;
            rdata_ff   <= `SCD_RDATA_RESET;
            freq_ff    <= 8'h00;
            freq_ok_ff <= 1'b0;
            range_ff   <= SCD_RANGE_16_32;
            pll_en_ff  <= 1'b0;
            mult_ff    <= 3'h0;
            tic_ff     <= 3'h0;
            isa_en_ff  <= 1'b1;
            loc_en_ff  <= 1'b0;
            state_ff   <= SCD_ST_HOLD;
            cnt_ff     <= '0;
            rsto_ff    <= 1'b0;
        end else begin
            index_ff   <= nxt_index;
            rdata_ff   <= nxt_rdata;
            freq_ff    <= nxt_freq;
            freq_ok_ff <= nxt_freq_ok;
            range_ff   <= nxt_range;
            pll_en_ff  <= nxt_pll_en;
            mult_ff    <= nxt_mult;
            tic_ff     <= nxt_tic;
            isa_en_ff  <= nxt_isa_en;
            loc_en_ff  <= nxt_loc_en;
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            rsto_ff    <= nxt_rsto;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io_rdata_out                      = rdata_ff;
    assign host_clock_freq_mhz_out           = freq_ff;
    assign host_clock_code_valid_out         = freq_ok_ff;
    assign host_clock_input_range_select_out = range_ff;
    assign host_clock_pll_enable_out         = pll_en_ff;
    assign core_multiplier_select_out        = mult_ff;
    assign core_dll_tic_out                  = tic_ff;
    assign isa_bus_enable_out                = isa_en_ff;
    assign local_bus_enable_out              = loc_en_ff;
    assign system_reset_output_n_out         = rsto_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    a_mirror_read: assert property (
        io_rd_in && io_addr_in == `SCD_DATA_PORT && index_ff == `SCD_MIRROR_INDEX
        |=> io_rdata_out[7:3] == $past(hclk_code))
        else $error("mirror read does not show sampled host clock straps");
    a_rsv_bits: assert property (
        io_rd_in && io_addr_in == `SCD_DATA_PORT && index_ff == `SCD_MIRROR_INDEX
        |=> io_rdata_out[2:0] == 3'h0)
        else $error("reserved mirror bits not zero");
    a_freq_top: assert property (
        hclk_code == 5'h1f |=> host_clock_freq_mhz_out == 8'h85 && host_clock_code_valid_out)
        else $error("top host clock code not decoded");
    a_pll_reserved: assert property (
        cfg.straps[`SCD_LN_RANGE_HI:`SCD_LN_RANGE_LO] == 2'b11 |=> !host_clock_pll_enable_out)
        else $error("pll enabled for reserved range");
    a_mult_x4: assert property (
        {cfg.straps[`SCD_LN_MUL_HI], cfg.straps[`SCD_LN_MUL_LO]} == 2'b00
        |=> core_multiplier_select_out == 3'h4)
        else $error("multiplier code 00 not x4");
    a_tic_follow: assert property (
        ##1 core_dll_tic_out == $past(cfg.straps[`SCD_LN_TIC_HI:`SCD_LN_TIC_LO]))
        else $error("dll tic not following straps");
    a_bus_exclusive: assert property (
        ##1 (isa_bus_enable_out != local_bus_enable_out)
        && (local_bus_enable_out == $past(cfg.straps[`SCD_LN_BUS_SEL])))
        else $error("bus selection wrong");
    a_rsto_low: assert property (
        !cfg.pin_high |=> !system_reset_output_n_out)
        else $error("reset output high while reset input low");
    a_rsto_delay: assert property (
        $rose(system_reset_output_n_out) |-> $past(cfg.pin_high, 26) && !$past(cfg.pin_high, 27))
        else $error("reset output release delay wrong");
    a_cfg_held: assert property (
        cfg.pin_high && $past(cfg.pin_high, 2) |-> $stable(core_multiplier_select_out)
        && $stable(isa_bus_enable_out) && $stable(host_clock_freq_mhz_out))
        else $error("decoded values changed after release");

    c_rsto_rise: cover property ($rose(system_reset_output_n_out));
    c_mirror_rd: cover property (io_rd_in && io_addr_in == `SCD_DATA_PORT && index_ff == `SCD_MIRROR_INDEX);
    c_local_bus: cover property (local_bus_enable_out && system_reset_output_n_out);
endmodule

`default_nettype wire

// File: scd_board_straps.sv
// Purpose: board side of the strap lines: pull resistors and bus traffic after reset output rises
// Assumes: straps are only meaningful while the reset pin is low
// Notes:   after reset output rises the lines carry memory traffic, modelled as a toggling pattern
`timescale 1ns/100ps
`default_nettype none

module scd_board_straps
    import scd_pkg::*;
(
    input  wire logic       clock_in,
    input  wire scd_strap_t resistor_value_in,
    input  wire logic       system_reset_input_n_in,
    input  wire logic       system_reset_output_n_in,
    output scd_strap_t      strap_memory_data_line_out
);
    initial strap_memory_data_line_out = '0;

    // --------------------------------------------------------
    // strap lines
    // --------------------------------------------------------
    always @(posedge clock_in) begin
        if (!system_reset_input_n_in) begin
            strap_memory_data_line_out <= resistor_value_in;
        end else if (system_reset_output_n_in) begin
            // bus in use: lines no longer show the straps
            strap_memory_data_line_out <= ~strap_memory_data_line_out;
        end
    end
endmodule

`default_nettype wire

// File: strap_clock_config_decoder_tb_top.sv
// Purpose: self-checking bench of the strap clock configuration decoder
// Assumes: 25 MHz clock, inputs driven by non-blocking assignment at the rising edge
// Notes:   pin path 2 cycles, reset output delay and one hold-state cycle give the release-to-high count
`timescale 1ns/100ps
`default_nettype none
`include "scd_consts.svh"

module strap_clock_config_decoder_tb_top;
    import scd_pkg::*;

    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        pin_n    = 1'b0;
    scd_strap_t  board_value = '0;
    scd_strap_t  lines;
    logic [15:0] io_addr  = 16'h0000;
    logic        io_wr    = 1'b0;
    logic        io_rd    = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  rdata, freq;
    logic        valid, pll_en, isa_en, loc_en, rsto_n;
    logic [1:0]  rng;
    logic [2:0]  mul, tic;
    int          fails = 0;
    int          cmp_count = 0;
    logic [4:0]  fc_tab  [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h13, 5'h19, 5'h1f};
    logic [7:0]  mhz_tab [8] = '{8'd25, 8'd50, 8'd60, 8'd66, 8'd75, 8'd90, 8'd100, 8'd133};
    logic [2:0]  mul_tab [4] = '{3'd4, 3'd1, 3'd3, 3'd2};

    always #20 clock_in = ~clock_in;

    strap_clock_config_decoder DUT (
        .clock_in                          (clock_in),
        .reset_in                          (reset_in),
        .system_reset_input_n_in           (pin_n),
        .strap_memory_data_line_in         (lines),
        .io_addr_in                        (io_addr),
        .io_wr_in                          (io_wr),
        .io_rd_in                          (io_rd),
        .io_wdata_in                       (io_wdata),
        .io_rdata_out                      (rdata),
        .host_clock_freq_mhz_out           (freq),
        .host_clock_code_valid_out         (valid),
        .host_clock_input_range_select_out (rng),
        .host_clock_pll_enable_out         (pll_en),
        .core_multiplier_select_out        (mul),
        .core_dll_tic_out                  (tic),
        .isa_bus_enable_out                (isa_en),
        .local_bus_enable_out              (loc_en),
        .system_reset_output_n_out         (rsto_n)
    );

    scd_board_straps board (
        .clock_in                   (clock_in),
        .resistor_value_in          (board_value),
        .system_reset_input_n_in    (pin_n),
        .system_reset_output_n_in   (rsto_n),
        .strap_memory_data_line_out (lines)
    );

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_in);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clock_in);
        io_wr    <= 1'b0;
    endtask

    task automatic io_read(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clock_in);
        io_rd   <= 1'b0;
        @(posedge clock_in);
        #1 check(rdata, exp);
    endtask

    task automatic check_outs(input logic [4:0] fc, input logic [7:0] mhz, input logic [1:0] r,
                              input logic [1:0] mc, input logic [2:0] t, input logic b);
        check(freq, mhz);
        check({7'h00, valid}, {7'h00, mhz != 8'h00});
        check({6'h00, rng}, {6'h00, r});
        check({7'h00, pll_en}, {7'h00, r != 2'b11});
        check({5'h00, mul}, {5'h00, mul_tab[mc]});
        check({5'h00, tic}, {5'h00, t});
        check({6'h00, isa_en, loc_en}, {6'h00, ~b, b});
    endtask

    // one reset-pin cycle with the given strap set, then decode and mirror checks
    task automatic run_cfg(input logic [4:0] fc, input logic [7:0] mhz, input logic [1:0] r,
                           input logic [1:0] mc, input logic [2:0] t, input logic b);
        scd_strap_t s;
        int         n;
        s = {47{t[0] ^ b}};
        {s[`SCD_LN_HF4], s[`SCD_LN_HF3], s[`SCD_LN_HF2], s[`SCD_LN_HF1], s[`SCD_LN_HF0]} = fc;
        {s[`SCD_LN_RANGE_HI], s[`SCD_LN_RANGE_LO]} = r;
        {s[`SCD_LN_MUL_HI], s[`SCD_LN_MUL_LO]} = mc;
        s[`SCD_LN_TIC_HI:`SCD_LN_TIC_LO] = t;
        s[`SCD_LN_BUS_SEL] = b;
        @(posedge clock_in);
        board_value <= s;
        pin_n       <= 1'b0;
        repeat (6) @(posedge clock_in);
        #1 check({7'h00, rsto_n}, 8'h00);
        @(posedge clock_in);
        pin_n <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            #1 n++;
        end while (rsto_n !== 1'b1 && n < 60);
        check(n[7:0], 8'(2 + `SCD_RSTO_DELAY_CYC + 1));
        check_outs(fc, mhz, r, mc, t, b);
        io_write(`SCD_INDEX_PORT, `SCD_MIRROR_INDEX);
        io_read(`SCD_DATA_PORT, {fc, `SCD_RSV_BITS});
        io_read(`SCD_INDEX_PORT, `SCD_MIRROR_INDEX);
        io_write(`SCD_DATA_PORT, 8'hff);
        io_read(`SCD_DATA_PORT, {fc, `SCD_RSV_BITS});
        repeat (8) @(posedge clock_in);
        #1 check_outs(fc, mhz, r, mc, t, b);
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_in);
        #1 check(freq, 8'h00);
        check({3'h0, valid, pll_en, isa_en, loc_en, rsto_n}, 8'h04);
        @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            run_cfg(fc_tab[i], mhz_tab[i], i[1:0], 2'(i + 1), i[2:0], i[0]);
            $display("test %0d done", i);
        end
        run_cfg(5'h04, 8'h00, 2'b11, 2'b01, 3'b010, 1'b0);
        $display("test undefined code done");
        io_write(`SCD_INDEX_PORT, 8'h5e);
        io_read(`SCD_DATA_PORT, 8'h00);
        io_read(16'h0024, 8'h00);
        $display("test refusals done");
        @(posedge clock_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1 check(freq, 8'h00);
        check({5'h00, isa_en, loc_en, rsto_n}, 8'h04);
        $display("test reset done");
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge clock_in);
        fails++;
        stop_test();
    end
endmodule

`default_nettype wire
